// *** src/host_port_pkg.sv ***
// Shared constants and carriers for the host bus and multipurpose pin block.
// Assumes one 100 MHz clock and a CPU bus sampled synchronously to it.
package host_port_pkg;

  // Register select decode
  localparam logic [3:0] AltEnAddr  = 4'h4;  // W/R: alternate-function enables
  localparam logic [3:0] IntAddr    = 4'h5;  // R: interrupt status, W: interrupt mask
  localparam logic [3:0] InPortAddr = 4'hD;  // R: input port, W: output configuration
  localparam logic [3:0] SetOutAddr = 4'hE;  // W: set output latch bits
  localparam logic [3:0] ClrOutAddr = 4'hF;  // W: clear output latch bits

  // Output configuration fields
  localparam int Op5AltBit = 5;
  localparam int Op6AltBit = 6;
  localparam int Op7AltBit = 7;

  // Alternate-enable fields; bits 0..6 follow input numbers
  localparam int CtsABit     = 0;
  localparam int CtsBBit     = 1;
  localparam int CtClkBit    = 2;
  localparam int TxAClkBit   = 3;
  localparam int RxAClkBit   = 4;
  localparam int TxBClkBit   = 5;
  localparam int RxBClkBit   = 6;
  localparam int Op5FullBit  = 7;  // 1: fifo full flag, 0: receive ready

  // Values after reset
  localparam logic [7:0] ImrReset   = 8'h00;
  localparam logic [7:0] OpcrReset  = 8'h00;
  localparam logic [7:0] LatchReset = 8'h00;
  localparam logic [7:0] AltReset   = 8'h00;

  localparam int ExtClkCount = 5;  // Inputs 2..6 carry clock alternates

  // Host bus request as seen on the pins
  typedef struct packed {
    logic       csN;
    logic       readStrobeN;
    logic       writeStrobeN;
    logic [3:0] regSelect;
    logic [7:0] wrData;
  } hostReq_t;

  // Pin with output enable; oeN low while the pin is driven
  typedef struct packed {
    logic level;
    logic oeN;
  } drivePin_t;

  // Timing pulses to the serial datapath
  typedef struct packed {
    logic ctExtTick;
    logic txAShift;
    logic rxASample;
    logic txBShift;
    logic rxBSample;
  } clkPulses_t;

  typedef struct packed {
    logic [ExtClkCount-1:0] prev;
  } edgeState_t;

  typedef struct packed {
    logic [7:0] imr;
    logic [7:0] opcr;
    logic [7:0] outLatch;
    logic [7:0] altEn;
    logic       wrSeen;
    logic [7:0] rdData;
    logic       rdOeN;
    drivePin_t  intPin;
    drivePin_t  op5;
    drivePin_t  op6;
    drivePin_t  op7;
    logic       ctsAN;
    logic       ctsBN;
    clkPulses_t pulses;
    logic       linkEnable;
    logic       regWrite;
    logic       regRead;
    logic [3:0] regAddr;
    logic [7:0] regWrData;
  } hostState_t;

endpackage

// *** src/ext_clk_edge.sv ***
// Edge finder for the multipurpose inputs that may carry external clocks.
// Assumes inputs already synchronous to ref_clk; outputs are combinational.
module ext_clk_edge (
  input  wire logic                                 ref_clk,
  input  wire logic                                 rst_n,
  input  wire logic [host_port_pkg::ExtClkCount-1:0] level,
  output      logic [host_port_pkg::ExtClkCount-1:0] rise,
  output      logic [host_port_pkg::ExtClkCount-1:0] fall
);

  host_port_pkg::edgeState_t s_q;
  host_port_pkg::edgeState_t s_d;

  // Previous level per input
  always_comb begin
    s_d.prev = level;
  end

  // Reset to low so a high input after reset shows one rise
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q.prev <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // One edge detector per input
  for (genvar i = 0; i < host_port_pkg::ExtClkCount; i++) begin : g_edge
    assign rise[i] = level[i] & ~s_q.prev[i];
    assign fall[i] = ~level[i] & s_q.prev[i];
  end

endmodule

// *** src/host_port.sv ***
// Host bus port, interrupt pin and multipurpose pins of a dual serial controller.
// Assumes CPU strobes synchronous to ref_clk; serial datapath lies outside.
module host_port (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire host_port_pkg::hostReq_t   hostReq,
  output      logic [7:0]                hostDataBusOut,
  output      logic                      hostDataBusOeN,
  input  wire logic [7:0]                intSources,
  output      host_port_pkg::drivePin_t  intPin,
  input  wire logic                      chanBRxReady,
  input  wire logic                      chanBRxFifoFull,
  input  wire logic                      chanATxEmpty,
  input  wire logic                      chanBTxEmpty,
  output      host_port_pkg::drivePin_t  multiOut5,
  output      host_port_pkg::drivePin_t  multiOut6,
  output      host_port_pkg::drivePin_t  multiOut7,
  input  wire logic [6:0]                multiIn,
  output      logic                      chanAClearToSendN,
  output      logic                      chanBClearToSendN,
  output      host_port_pkg::clkPulses_t clkPulses,
  output      logic                      linkEnable,
  output      logic                      regWrite,
  output      logic                      regRead,
  output      logic [3:0]                regAddr,
  output      logic [7:0]                regWrData,
  input  wire logic [7:0]                extRdData
);

  host_port_pkg::hostState_t s_q;
  host_port_pkg::hostState_t s_d;

  logic [host_port_pkg::ExtClkCount-1:0] clkRise;
  logic [host_port_pkg::ExtClkCount-1:0] clkFall;

  // Edges on inputs 2..6
  ext_clk_edge u_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .level   (multiIn[6:2]),
    .rise    (clkRise),
    .fall    (clkFall)
  );

  logic       selected;
  logic       wrActive;
  logic       rdActive;
  logic       wrStart;
  logic [7:0] rdMux;
  logic [7:0] inPortView;
  logic       intAny;

  // Bus qualification
  always_comb begin
    selected = ~hostReq.csN;
    // overlap ignored; the design acts on neither strobe if both are low
    wrActive = selected & ~hostReq.writeStrobeN & hostReq.readStrobeN;
    rdActive = selected & ~hostReq.readStrobeN & hostReq.writeStrobeN;
    // One store per strobe, however long it is held
    wrStart  = wrActive & ~s_q.wrSeen;
    inPortView = {1'b0, ~multiIn};
    intAny = |(intSources & s_q.imr);
  end

  always_comb begin
    unique case (hostReq.regSelect)
      host_port_pkg::AltEnAddr:  rdMux = s_q.altEn;
      // raw source view for the host
      host_port_pkg::IntAddr:    rdMux = intSources;
      host_port_pkg::InPortAddr: rdMux = inPortView;
      default:                   rdMux = extRdData;  // Datapath registers
    endcase
  end

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.wrSeen = wrActive;

    // store on first cycle of a write
    if (wrStart) begin
      unique case (hostReq.regSelect)
        host_port_pkg::AltEnAddr:  s_d.altEn = hostReq.wrData;
        host_port_pkg::IntAddr:    s_d.imr   = hostReq.wrData;
        host_port_pkg::InPortAddr: s_d.opcr  = hostReq.wrData;
        // latch set and clear, ones act
        host_port_pkg::SetOutAddr: s_d.outLatch = s_q.outLatch | hostReq.wrData;
        host_port_pkg::ClrOutAddr: s_d.outLatch = s_q.outLatch & ~hostReq.wrData;
        default:                   s_d.altEn = s_q.altEn;  // Datapath owns it
      endcase
    end

    // Write and read notices toward the datapath registers
    s_d.regWrite  = wrStart;
    s_d.regRead   = rdActive;
    s_d.regAddr   = hostReq.regSelect;
    s_d.regWrData = hostReq.wrData;

    // drive bus only during a selected read
    s_d.rdOeN  = ~rdActive;
    // bit 0 stays bit 0, no lane swap
    s_d.rdData = rdActive ? rdMux : 8'h00;

    s_d.intPin.level = 1'b0;
    s_d.intPin.oeN   = ~intAny;

    if (s_q.opcr[host_port_pkg::Op5AltBit]) begin
      s_d.op5.level = 1'b0;
      s_d.op5.oeN   = s_q.altEn[host_port_pkg::Op5FullBit] ? ~chanBRxFifoFull
                                                             : ~chanBRxReady;
    end else begin
      s_d.op5.level = s_q.outLatch[5];
      s_d.op5.oeN   = 1'b0;
    end

    if (s_q.opcr[host_port_pkg::Op6AltBit]) begin
      s_d.op6.level = 1'b0;
      s_d.op6.oeN   = ~chanATxEmpty;
    end else begin
      s_d.op6.level = s_q.outLatch[6];
      s_d.op6.oeN   = 1'b0;
    end

    if (s_q.opcr[host_port_pkg::Op7AltBit]) begin
      s_d.op7.level = 1'b0;
      s_d.op7.oeN   = ~chanBTxEmpty;
    end else begin
      s_d.op7.level = s_q.outLatch[7];
      s_d.op7.oeN   = 1'b0;
    end

    // clear-to-send alternates; disabled means always clear
    s_d.ctsAN = s_q.altEn[host_port_pkg::CtsABit] ? multiIn[0] : 1'b0;
    s_d.ctsBN = s_q.altEn[host_port_pkg::CtsBBit] ? multiIn[1] : 1'b0;

    // counter clock on rising edge of input 2
    s_d.pulses.ctExtTick = s_q.altEn[host_port_pkg::CtClkBit] & clkRise[0];
    s_d.pulses.txAShift  = s_q.altEn[host_port_pkg::TxAClkBit] & clkFall[1];
    s_d.pulses.txBShift  = s_q.altEn[host_port_pkg::TxBClkBit] & clkFall[3];
    s_d.pulses.rxASample = s_q.altEn[host_port_pkg::RxAClkBit] & clkRise[2];
    s_d.pulses.rxBSample = s_q.altEn[host_port_pkg::RxBClkBit] & clkRise[4];

    s_d.linkEnable = 1'b1;
  end

  // State register; pins released and link held off in reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q.imr        <= host_port_pkg::ImrReset;
      s_q.opcr       <= host_port_pkg::OpcrReset;
      s_q.outLatch   <= host_port_pkg::LatchReset;
      s_q.altEn      <= host_port_pkg::AltReset;
      s_q.wrSeen     <= 1'b0;
      s_q.rdData     <= 8'h00;
      s_q.rdOeN      <= 1'b1;
      s_q.intPin     <= '{level: 1'b0, oeN: 1'b1};
      s_q.op5        <= '{level: 1'b0, oeN: 1'b1};
      s_q.op6        <= '{level: 1'b0, oeN: 1'b1};
      s_q.op7        <= '{level: 1'b0, oeN: 1'b1};
      s_q.ctsAN      <= 1'b0;
      s_q.ctsBN      <= 1'b0;
      s_q.pulses     <= '0;
      s_q.linkEnable <= 1'b0;
      s_q.regWrite   <= 1'b0;
      s_q.regRead    <= 1'b0;
      s_q.regAddr    <= 4'h0;
      s_q.regWrData  <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output straight from the state register
  assign hostDataBusOut    = s_q.rdData;
  assign hostDataBusOeN    = s_q.rdOeN;
  assign intPin            = s_q.intPin;
  assign multiOut5         = s_q.op5;
  assign multiOut6         = s_q.op6;
  assign multiOut7         = s_q.op7;
  assign chanAClearToSendN = s_q.ctsAN;
  assign chanBClearToSendN = s_q.ctsBN;
  assign clkPulses         = s_q.pulses;
  assign linkEnable        = s_q.linkEnable;
  assign regWrite          = s_q.regWrite;
  assign regRead           = s_q.regRead;
  assign regAddr           = s_q.regAddr;
  assign regWrData         = s_q.regWrData;

endmodule

// *** verif/host_port_asserts.sv ***
// Checker for the host port: bus strobes, interrupt pin, flag pin 6, reset.
// Assumes it is bound to host_port and sees only that module's ports.
module host_port_asserts (
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  input wire host_port_pkg::hostReq_t  hostReq,
  input wire logic                     hostDataBusOeN,
  input wire logic [7:0]               intSources,
  input wire host_port_pkg::drivePin_t intPin,
  input wire logic                     chanATxEmpty,
  input wire host_port_pkg::drivePin_t multiOut6,
  input wire logic                     regWrite,
  input wire logic                     linkEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Qualified strobes; a write counts once, at the edge its strobe falls
  sequence rdReq;
    !hostReq.csN && !hostReq.readStrobeN && hostReq.writeStrobeN;
  endsequence
  sequence wrStart;
    !hostReq.csN && !hostReq.writeStrobeN && hostReq.readStrobeN && $past(hostReq.writeStrobeN);
  endsequence

  a_read_drives_bus: assert property (rdReq |=> !hostDataBusOeN)
    else $error("read did not drive bus");
  a_bus_released: assert property ((hostReq.csN || hostReq.readStrobeN || !hostReq.writeStrobeN)
    |=> hostDataBusOeN)
    else $error("bus driven without read");
  a_write_pulse: assert property (wrStart |=> regWrite ##1 !regWrite)
    else $error("write not stored once");
  a_cs_blocks_write: assert property (hostReq.csN |=> !regWrite)
    else $error("write taken without select");
  a_both_ignored: assert property (!hostReq.csN && !hostReq.readStrobeN && !hostReq.writeStrobeN
    |=> !regWrite)
    else $error("write taken with both strobes");
  a_int_idle: assert property (intSources == 8'h00 |=> intPin.oeN && !intPin.level)
    else $error("interrupt without source");
  a_link_up: assert property ($past(rst_n) |-> linkEnable)
    else $error("link not enabled after reset");
  a_tx_a_flag: assert property ($rose(chanATxEmpty) |=> !multiOut6.oeN)
    else $error("output 6 not low on empty");
endmodule

bind host_port host_port_asserts chk (.ref_clk, .rst_n, .hostReq, .hostDataBusOeN, .intSources,
  .intPin, .chanATxEmpty, .multiOut6, .regWrite, .linkEnable);

// *** verif/host_cpu_model.sv ***
// Host CPU model driving the parallel bus, one access at a time.
// Assumes xfer is called from one thread; pins change at falling edges.
module host_cpu_model (
  input  wire logic                    ref_clk,
  input  wire logic [7:0]              busIn,
  input  wire logic                    busOeN,
  output      host_port_pkg::hostReq_t hostReq
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: deselected, both strobes high
  initial hostReq = 15'h7000;

  task automatic xfer(input logic [2:0] strb, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    @(negedge ref_clk);
    hostReq = {strb, a, d};
    @(posedge ref_clk);
    @(negedge ref_clk);
    // Bounded wait, so a dead read shows as bad data, not a hang
    while (strb == 3'b001 && busOeN !== 1'b0 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    q = busIn;
    // Released data lines do not keep the last value
    hostReq = {3'b111, a, ~d};
  endtask
endmodule

// *** verif/host_port_tb_top.sv ***
// Self-checking bench for host_port: register accesses, pins, clock pulses.
// Assumes the CPU model and checker are compiled ahead of this file.
module host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      ref_clk    = 1'b0;
  logic                      rst_n      = 1'b0;
  logic [7:0]                intSources = 8'h00;
  logic [6:0]                multiIn    = 7'h00;
  logic                      rxRdy      = 1'b0;
  logic                      rxFull     = 1'b0;
  logic                      txAE       = 1'b0;
  logic                      txBE       = 1'b0;
  host_port_pkg::hostReq_t   hostReq;
  host_port_pkg::drivePin_t  intPin, multiOut5, multiOut6, multiOut7;
  host_port_pkg::clkPulses_t clkPulses;
  logic [7:0]                busOut, rdQ, regWrData, hits;
  logic [3:0]                regAddr;
  logic                      busOeN, ctsAN, ctsBN, linkEnable, regWrite, regRead;
  int                        failures = 0, checksDone = 0, cycles = 0;

  host_port dut (.ref_clk, .rst_n, .hostReq, .hostDataBusOut(busOut), .hostDataBusOeN(busOeN),
    .intSources, .intPin, .chanBRxReady(rxRdy), .chanBRxFifoFull(rxFull), .chanATxEmpty(txAE),
    .chanBTxEmpty(txBE), .multiOut5, .multiOut6, .multiOut7, .multiIn, .chanAClearToSendN(ctsAN),
    .chanBClearToSendN(ctsBN), .clkPulses, .linkEnable, .regWrite, .regRead, .regAddr,
    .regWrData, .extRdData(8'h96));
  host_cpu_model cpu (.ref_clk, .busIn(busOut), .busOeN, .hostReq);

  // Free-running clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cpu.xfer(3'b010, a, d, rdQ);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    cpu.xfer(3'b001, a, 8'h00, rdQ);
    chk(rdQ, exp);
  endtask

  // One pin edge, then count pulses on its mapped timing line
  task automatic clk_edge(input int i, input logic lvl, input logic [7:0] exp);
    hits = 8'h00;
    @(negedge ref_clk);
    multiIn[i] = lvl;
    repeat (4) begin
      @(negedge ref_clk);
      // Kept as logic so an unknown pulse shows up as a mismatch
      hits = hits + 8'(clkPulses[6-i]);
    end
    chk(hits, exp);
  endtask

  // Hang guard, well above the hundred or so cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    idle(6);
    chk(8'({linkEnable, busOeN, intPin.oeN, multiOut6.oeN}), 8'h07);
    rst_n = 1'b1;
    idle(2);
    chk(8'({linkEnable, multiOut5, multiOut7}), 8'h10);
    wr(4'h4, 8'hA5);
    rd(4'h4, 8'hA5);
    cpu.xfer(3'b110, 4'h4, 8'h3C, rdQ);
    cpu.xfer(3'b000, 4'h4, 8'h3C, rdQ);
    rd(4'h4, 8'hA5);
    rd(4'h0, 8'h96);
    chk(8'({regRead, regAddr}), 8'h10);
    wr(4'h3, 8'h5A);
    chk(8'({regWrite, regAddr}), 8'h13);
    chk(regWrData, 8'h5A);
    idle(1);
    chk(8'(regWrite), 8'h00);
    rd(4'h4, 8'hA5);
    multiIn = 7'h35;
    rd(4'hD, 8'h4A);
    chk(8'({ctsAN, ctsBN}), 8'h02);
    intSources = 8'h06;
    rd(4'h5, 8'h06);
    chk(8'(intPin), 8'h01);
    wr(4'h5, 8'h04);
    idle(2);
    chk(8'(intPin), 8'h00);
    intSources = 8'h02;
    idle(2);
    chk(8'(intPin), 8'h01);
    wr(4'hE, 8'hE0);
    wr(4'hF, 8'h40);
    idle(2);
    chk(8'({multiOut5, multiOut6, multiOut7}), 8'h22);
    txAE = 1'b1;
    rxRdy = 1'b1;
    wr(4'hD, 8'hE0);
    idle(2);
    chk(8'({multiOut5, multiOut6, multiOut7}), 8'h11);
    txAE = 1'b0;
    txBE = 1'b1;
    wr(4'h4, 8'h7C);
    idle(2);
    chk(8'({multiOut5, multiOut6, multiOut7}), 8'h04);
    // Flag rises while output 6 is already in its alternate mode
    txAE = 1'b1;
    idle(2);
    chk(8'(multiOut6), 8'h00);
    multiIn = 7'h00;
    idle(4);
    for (int i = 2; i < 7; i++) begin
      clk_edge(i, 1'b1, 8'(i % 2 == 0));
      clk_edge(i, 1'b0, 8'(i % 2));
    end
    wr(4'h4, 8'h03);
    multiIn = 7'h02;
    idle(2);
    chk(8'({ctsAN, ctsBN}), 8'h01);
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    rd(4'h4, 8'h00);
    give_verdict();
  end
endmodule
